// [logic/tcc_pkg.sv]
package tcc_pkg;
	// =====================================================
	// sizes
	localparam int unsigned CH_N    = 8;
	localparam int unsigned CNT_W   = 16;
	localparam int unsigned BYTE_W  = 8;
	localparam int unsigned PR_W    = 3;
	localparam int unsigned PRESC_W = 7;
	// =====================================================
	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_IO_SEL    = 8'h00;
	localparam logic [7:0] ADDR_OVR_MASK  = 8'h02;
	localparam logic [7:0] ADDR_OVR_DATA  = 8'h03;
	localparam logic [7:0] ADDR_CNT_HI    = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO    = 8'h05;
	localparam logic [7:0] ADDR_SYS_ONE   = 8'h06;
	localparam logic [7:0] ADDR_ACT_HI    = 8'h08;
	localparam logic [7:0] ADDR_ACT_LO    = 8'h09;
	localparam logic [7:0] ADDR_EDGE_HI   = 8'h0A;
	localparam logic [7:0] ADDR_EDGE_LO   = 8'h0B;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h0C;
	localparam logic [7:0] ADDR_SYS_TWO   = 8'h0D;
	localparam logic [7:0] ADDR_FLAGS     = 8'h0E;
	localparam logic [7:0] ADDR_FLAGS_TWO = 8'h0F;
	localparam logic [3:0] ADDR_CH_NIB    = 4'h1;
	// =====================================================
	// field positions and values
	localparam int unsigned FFCA_BIT  = 4;
	localparam int unsigned OVF_BIT   = 7;
	localparam int unsigned RISE_BIT  = 0;
	localparam int unsigned FALL_BIT  = 1;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [7:0]  SPAN_ONE  = 8'h01;
	localparam logic [6:0]  PRESC_ZERO = 7'h00;
	localparam logic [6:0]  PRESC_ONE  = 7'h01;
	// compare output action codes
	typedef enum logic [1:0] {
		ACT_OFF    = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_LOW    = 2'h2,
		ACT_HIGH   = 2'h3
	} tcc_act_t;
	// second system control register layout
	typedef struct packed {
		logic       overflow_irq_enable;
		logic [2:0] unused;
		logic       counter_reset_on_ch7;
		logic [2:0] prescale_select;
	} tcc_sys2_t;
	localparam tcc_sys2_t SYS2_RESET = 8'h00;
endpackage

// [logic/tcc_timer.sv]
// Behaviour
// R1: on a compare, action 00 none, 01 toggle, 10 low, 11 high
// R2: nonzero action makes the pin an output driven by the compare line
// R3: software clears a channel's ch7 mask bit so its own action reaches the pin
// R4: pulse accumulator alone needs compare select, no action, mask bit clear
// R5: edge setting 00 off, 01 rising, 10 falling, 11 both edges capture
// R6: channel interrupt enable gates the matching flag onto the interrupt
// R7: overflow enable requests an interrupt while the overflow flag is set
// R8: counter reset enable makes a channel 7 compare clear the counter
// R9: channel 7 value zero with reset enable holds the counter at zero
// R10: channel 7 value all ones with reset enable never sets overflow
// R11: prescale select divides the bus clock by two to the field value
// R12: new prescale takes effect only when all prescaler stages are zero
// R13: channel flag sets on its capture or compare event
// R14: writing one clears a channel flag, zero leaves it
// R15: fast clear: capture read or compare write of a channel clears its flag
// R16: channel 7 compare drives masked pins to the channel 7 data bits
// R17: overflow flag sets on wrap from all ones, cleared by writing bit 7
// R18: fast clear: any access to the counter clears the overflow flag
// R19: all control, enable and flag bits reset to zero
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module tcc_timer (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rd_data_o,
	input  wire logic [7:0] ioc_in_i,
	output logic      [7:0] ioc_out_o,
	output logic      [7:0] ioc_oe_o,
	output logic            irq_o
);
	// =====================================================
	// state
	logic [7:0]       io_sel_reg;
	logic [7:0]       ovr_mask_reg;
	logic [7:0]       ovr_data_reg;
	logic             ffca_reg;
	logic [7:0]       act_hi_reg;
	logic [7:0]       act_lo_reg;
	logic [7:0]       edge_hi_reg;
	logic [7:0]       edge_lo_reg;
	logic [7:0]       irq_en_reg;
	tcc_pkg::tcc_sys2_t sys2_reg;
	logic [7:0]       flags_reg;
	logic [7:0]       flags_next;
	logic             ovf_reg;
	logic             ovf_next;
	logic [15:0]      cnt_reg;
	logic [6:0]       presc_reg;
	logic [2:0]       pr_act_reg;
	logic [7:0][15:0] tc_reg;
	logic [7:0][15:0] tc_next;
	logic [7:0]       oc_reg;
	logic [7:0]       oc_next;
	logic [7:0]       oe_reg;
	logic [7:0]       oe_next;
	logic [7:0]       sync1_reg;
	logic [7:0]       sync2_reg;
	logic [7:0]       prev_reg;
	logic [7:0]       rd_data_reg;
	logic [7:0]       rd_mux;
	logic             irq_reg;

	// =====================================================
	// bus decode
	logic        wr_flags;
	logic        wr_flags2;
	logic        cnt_access;
	logic        tc_sel;
	logic [2:0]  tc_ch;
	logic        tc_hi;
	logic [15:0] act_all;
	logic [15:0] edge_all;

	assign wr_flags   = wr_i & (addr_i == tcc_pkg::ADDR_FLAGS);
	assign wr_flags2  = wr_i & (addr_i == tcc_pkg::ADDR_FLAGS_TWO);
	assign cnt_access = (rd_i | wr_i) & ((addr_i == tcc_pkg::ADDR_CNT_HI)
		| (addr_i == tcc_pkg::ADDR_CNT_LO));
	assign tc_sel     = (addr_i[7:4] == tcc_pkg::ADDR_CH_NIB);
	assign tc_ch      = addr_i[3:1];
	assign tc_hi      = ~addr_i[0];
	assign act_all    = {act_hi_reg, act_lo_reg};
	assign edge_all   = {edge_hi_reg, edge_lo_reg};

	// =====================================================
	// prescaler: divide by 2**select, change only at all-zero
	logic [7:0] presc_span;
	logic [7:0] presc_low;
	logic [6:0] presc_mask;
	logic       tick;

	assign presc_span = tcc_pkg::SPAN_ONE << pr_act_reg; // R11
	assign presc_low  = presc_span - tcc_pkg::SPAN_ONE;
	assign presc_mask = presc_low[tcc_pkg::PRESC_W-1:0];
	assign tick       = &(presc_reg | ~presc_mask); // R11

	// free-running stages; the active select is swapped at zero
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			presc_reg  <= tcc_pkg::PRESC_ZERO;
			pr_act_reg <= 3'h0;
		end else begin
			presc_reg <= presc_reg + tcc_pkg::PRESC_ONE;
			if (presc_reg == tcc_pkg::PRESC_ZERO) begin
				pr_act_reg <= sys2_reg.prescale_select; // R12
			end
		end
	end

	// =====================================================
	// main counter and overflow
	logic [7:0] comp_hit;
	logic [7:0] cap_hit;
	logic [7:0] fast_clr;
	logic       cnt_rst;
	logic       ovf_evt;
	logic       ovf_clr;

	// a wrap caused by the channel 7 reset is not an overflow
	assign cnt_rst  = sys2_reg.counter_reset_on_ch7 & comp_hit[7]; // R8
	assign ovf_evt  = tick & (cnt_reg == tcc_pkg::CNT_MAX) & ~cnt_rst; // R10
	assign ovf_clr  = (wr_flags2 & wr_data_i[tcc_pkg::OVF_BIT])
		| (ffca_reg & cnt_access); // R18
	assign ovf_next = ovf_evt | (ovf_reg & ~ovf_clr); // R17

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_reg <= tcc_pkg::CNT_ZERO;
		end else if (tick) begin
			cnt_reg <= cnt_rst ? tcc_pkg::CNT_ZERO
				: cnt_reg + tcc_pkg::CNT_ONE; // R9
		end
	end

	// =====================================================
	// pin synchroniser and edge detect
	logic [7:0] pin_rise;
	logic [7:0] pin_fall;

	assign pin_rise = sync2_reg & ~prev_reg;
	assign pin_fall = ~sync2_reg & prev_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync1_reg <= tcc_pkg::BYTE_ZERO;
			sync2_reg <= tcc_pkg::BYTE_ZERO;
			prev_reg  <= tcc_pkg::BYTE_ZERO;
		end else begin
			sync1_reg <= ioc_in_i;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// =====================================================
	// per-channel capture, compare and pin logic
	for (genvar i = 0; i < tcc_pkg::CH_N; i++) begin : g_ch
		logic [1:0]  act;
		logic [1:0]  edg;
		logic        sel;
		logic        act_val;
		logic [15:0] wr_val;

		assign act = act_all[2*i +: 2];
		assign edg = edge_all[2*i +: 2];
		assign sel = tc_sel & (tc_ch == 3'(i));
		// compare only counts on a prescaled tick
		assign comp_hit[i] = tick & io_sel_reg[i] & (cnt_reg == tc_reg[i]);
		assign cap_hit[i]  = ~io_sel_reg[i]
			& ((edg[tcc_pkg::RISE_BIT] & pin_rise[i])
			| (edg[tcc_pkg::FALL_BIT] & pin_fall[i])); // R5
		assign fast_clr[i] = ffca_reg & sel
			& ((rd_i & ~io_sel_reg[i]) | (wr_i & io_sel_reg[i])); // R15
		assign wr_val = tc_hi ? {wr_data_i, tc_reg[i][tcc_pkg::BYTE_W-1:0]}
			: {tc_reg[i][tcc_pkg::CNT_W-1:tcc_pkg::BYTE_W], wr_data_i};
		// capture beats a bus write; writes only land in compare mode
		assign tc_next[i] = cap_hit[i] ? cnt_reg
			: (wr_i & sel & io_sel_reg[i]) ? wr_val : tc_reg[i];
		assign act_val = (act == tcc_pkg::ACT_TOGGLE) ? ~oc_reg[i]
			: (act == tcc_pkg::ACT_LOW) ? 1'h0
			: (act == tcc_pkg::ACT_HIGH) ? 1'h1 : oc_reg[i]; // R1
		// channel 7 override wins over the channel's own action
		assign oc_next[i] = (comp_hit[7] & ovr_mask_reg[i]) ? ovr_data_reg[i]
			: comp_hit[i] ? act_val : oc_reg[i]; // R16
		assign oe_next[i] = io_sel_reg[i]
			& ((act != tcc_pkg::ACT_OFF) | ovr_mask_reg[i]); // R2

		toggle_act_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
			comp_hit[i] && !(comp_hit[7] && ovr_mask_reg[i])
			&& act == tcc_pkg::ACT_TOGGLE |=> oc_reg[i] != $past(oc_reg[i]))
			else $error("toggle action missed"); // R1
		level_act_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
			comp_hit[i] && !(comp_hit[7] && ovr_mask_reg[i]) && act[1]
			|=> oc_reg[i] == $past(act[0]))
			else $error("drive level action wrong"); // R1
		pin_drive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
			io_sel_reg[i] && act != tcc_pkg::ACT_OFF ##1 io_sel_reg[i]
			|-> ioc_oe_o[i])
			else $error("pin not driven for active action"); // R2
	end

	// =====================================================
	// flags: a set in the same cycle as a clear wins
	logic [7:0] flag_clr;

	assign flag_clr   = (wr_flags ? wr_data_i : tcc_pkg::BYTE_ZERO)
		| fast_clr; // R14
	assign flags_next = (comp_hit | cap_hit) | (flags_reg & ~flag_clr); // R13

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flags_reg <= tcc_pkg::BYTE_ZERO;
			ovf_reg   <= 1'h0;
			tc_reg    <= '0;
			oc_reg    <= tcc_pkg::BYTE_ZERO;
			oe_reg    <= tcc_pkg::BYTE_ZERO;
			irq_reg   <= 1'h0;
		end else begin
			flags_reg <= flags_next;
			ovf_reg   <= ovf_next;
			tc_reg    <= tc_next;
			oc_reg    <= oc_next;
			oe_reg    <= oe_next;
			irq_reg   <= (|(flags_reg & irq_en_reg))
				| (ovf_reg & sys2_reg.overflow_irq_enable); // R6 R7
		end
	end

	// =====================================================
	// control registers, all clear at reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			io_sel_reg   <= tcc_pkg::BYTE_ZERO; // R19
			ovr_mask_reg <= tcc_pkg::BYTE_ZERO;
			ovr_data_reg <= tcc_pkg::BYTE_ZERO;
			ffca_reg     <= 1'h0;
			act_hi_reg   <= tcc_pkg::BYTE_ZERO;
			act_lo_reg   <= tcc_pkg::BYTE_ZERO;
			edge_hi_reg  <= tcc_pkg::BYTE_ZERO;
			edge_lo_reg  <= tcc_pkg::BYTE_ZERO;
			irq_en_reg   <= tcc_pkg::BYTE_ZERO;
			sys2_reg     <= tcc_pkg::SYS2_RESET;
		end else if (wr_i) begin
			unique case (addr_i)
				tcc_pkg::ADDR_IO_SEL:   io_sel_reg   <= wr_data_i;
				tcc_pkg::ADDR_OVR_MASK: ovr_mask_reg <= wr_data_i;
				tcc_pkg::ADDR_OVR_DATA: ovr_data_reg <= wr_data_i;
				tcc_pkg::ADDR_SYS_ONE:  ffca_reg <= wr_data_i[tcc_pkg::FFCA_BIT];
				tcc_pkg::ADDR_ACT_HI:   act_hi_reg   <= wr_data_i;
				tcc_pkg::ADDR_ACT_LO:   act_lo_reg   <= wr_data_i;
				tcc_pkg::ADDR_EDGE_HI:  edge_hi_reg  <= wr_data_i;
				tcc_pkg::ADDR_EDGE_LO:  edge_lo_reg  <= wr_data_i;
				tcc_pkg::ADDR_IRQ_EN:   irq_en_reg   <= wr_data_i;
				tcc_pkg::ADDR_SYS_TWO: begin
					sys2_reg        <= wr_data_i;
					sys2_reg.unused <= 3'h0;
				end
				default: ; // counter writes leave the count unchanged
			endcase
		end
	end

	// =====================================================
	// read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = tcc_pkg::BYTE_ZERO;
		if (tc_sel) begin
			rd_mux = tc_hi ? tc_reg[tc_ch][tcc_pkg::CNT_W-1:tcc_pkg::BYTE_W]
				: tc_reg[tc_ch][tcc_pkg::BYTE_W-1:0];
		end else begin
			unique case (addr_i)
				tcc_pkg::ADDR_IO_SEL:    rd_mux = io_sel_reg;
				tcc_pkg::ADDR_OVR_MASK:  rd_mux = ovr_mask_reg;
				tcc_pkg::ADDR_OVR_DATA:  rd_mux = ovr_data_reg;
				tcc_pkg::ADDR_CNT_HI:
					rd_mux = cnt_reg[tcc_pkg::CNT_W-1:tcc_pkg::BYTE_W];
				tcc_pkg::ADDR_CNT_LO:    rd_mux = cnt_reg[tcc_pkg::BYTE_W-1:0];
				tcc_pkg::ADDR_SYS_ONE:   rd_mux[tcc_pkg::FFCA_BIT] = ffca_reg;
				tcc_pkg::ADDR_ACT_HI:    rd_mux = act_hi_reg;
				tcc_pkg::ADDR_ACT_LO:    rd_mux = act_lo_reg;
				tcc_pkg::ADDR_EDGE_HI:   rd_mux = edge_hi_reg;
				tcc_pkg::ADDR_EDGE_LO:   rd_mux = edge_lo_reg;
				tcc_pkg::ADDR_IRQ_EN:    rd_mux = irq_en_reg;
				tcc_pkg::ADDR_SYS_TWO:   rd_mux = sys2_reg;
				tcc_pkg::ADDR_FLAGS:     rd_mux = flags_reg;
				tcc_pkg::ADDR_FLAGS_TWO: rd_mux[tcc_pkg::OVF_BIT] = ovf_reg;
				default:                 rd_mux = tcc_pkg::BYTE_ZERO;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rd_data_reg <= tcc_pkg::BYTE_ZERO;
		end else begin
			rd_data_reg <= rd_i ? rd_mux : tcc_pkg::BYTE_ZERO;
		end
	end

	assign rd_data_o = rd_data_reg;
	assign ioc_out_o = oc_reg;
	assign ioc_oe_o  = oe_reg;
	assign irq_o     = irq_reg;

	// =====================================================
	// checks
	modulus_reset_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cnt_rst |=> cnt_reg == tcc_pkg::CNT_ZERO)
		else $error("counter not reset by channel 7"); // R8
	hold_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		sys2_reg.counter_reset_on_ch7 && io_sel_reg[7] && tick
		&& tc_reg[7] == tcc_pkg::CNT_ZERO && cnt_reg == tcc_pkg::CNT_ZERO
		|=> cnt_reg == tcc_pkg::CNT_ZERO)
		else $error("counter left zero"); // R9
	no_wrap_ovf_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cnt_rst && cnt_reg == tcc_pkg::CNT_MAX && !ovf_reg |=> !ovf_reg)
		else $error("overflow set on modulus reset"); // R10
	ovf_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ovf_evt |=> ovf_reg ##1 1'h1)
		else $error("overflow flag not set on wrap"); // R17
	ovf_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ffca_reg && cnt_access && !ovf_evt |=> !ovf_reg)
		else $error("counter access did not clear overflow"); // R18
	presc_swap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$changed(pr_act_reg) |-> $past(presc_reg) == tcc_pkg::PRESC_ZERO)
		else $error("prescale changed mid-count"); // R12
	div_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		pr_act_reg == 3'h0 |-> tick)
		else $error("divide by one skipped a tick"); // R11
	flag_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		comp_hit[0] || cap_hit[0] |=> flags_reg[0])
		else $error("channel flag not set"); // R13
	flag_w1c_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		wr_flags && wr_data_i[0] && !comp_hit[0] && !cap_hit[0]
		|=> !flags_reg[0])
		else $error("write one did not clear flag"); // R14
	flag_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		fast_clr[1] && !comp_hit[1] && !cap_hit[1] |=> !flags_reg[1])
		else $error("fast clear missed channel flag"); // R15
	override_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		comp_hit[7] && ovr_mask_reg[2] |=> oc_reg[2] == $past(ovr_data_reg[2]))
		else $error("channel 7 override not applied"); // R16
	irq_chan_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		flags_reg[3] && irq_en_reg[3] |=> irq_o)
		else $error("enabled flag raised no interrupt"); // R6
	irq_ovf_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		##1 irq_o |-> $past(|(flags_reg & irq_en_reg))
		|| $past(ovf_reg && sys2_reg.overflow_irq_enable))
		else $error("interrupt without enabled cause"); // R7
	cap_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cap_hit[4] |=> tc_reg[4] == $past(cnt_reg))
		else $error("capture did not latch counter"); // R5
endmodule

// [verification/tcc_pin_model.sv]
`timescale 1ns/1ps
// =====================================================
// outside circuit on the eight timer pins
module tcc_pin_model (
	input  wire logic [7:0] ioc_out_i,
	input  wire logic [7:0] ioc_oe_i,
	input  wire logic [7:0] ext_level_i,
	output logic      [7:0] pin_o
);
	// an enabled pin carries the compare line, a released one the outside level
	assign pin_o = (ioc_oe_i & ioc_out_i) | (~ioc_oe_i & ext_level_i);
endmodule

// [verification/timer_channel_control_test.sv]
`timescale 1ns/1ps
module timer_channel_control_test;
	// =====================================================
	// signals
	logic       clk_sys_i;
	logic       rst_i;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rd_data;
	logic [7:0] ext;
	logic [7:0] pins;
	logic [7:0] ioc_out;
	logic [7:0] ioc_oe;
	logic       irq;
	logic [7:0] hi;
	logic [7:0] lo;
	int         cmp_count;
	int         err_total;
	localparam logic [7:0] RST_ADDR [13] = '{8'h00, 8'h02, 8'h03, 8'h06, 8'h08, 8'h09,
		8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h07};
	localparam logic [1:0] ACTS [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
	localparam logic [4:0] EXP_OUT  = 5'h05;
	localparam logic [4:0] EXP_OE   = 5'h0F;
	// =====================================================
	// design and pin partner
	tcc_timer dut (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.addr_i    (addr),
		.wr_data_i (wdata),
		.wr_i      (wr),
		.rd_i      (rd),
		.rd_data_o (rd_data),
		.ioc_in_i  (pins),
		.ioc_out_o (ioc_out),
		.ioc_oe_o  (ioc_oe),
		.irq_o     (irq)
	);
	tcc_pin_model pin_side (
		.ioc_out_i   (ioc_out),
		.ioc_oe_i    (ioc_oe),
		.ext_level_i (ext),
		.pin_o       (pins)
	);
	// 50 MHz bus clock
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// =====================================================
	// tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// each access leaves a gap cycle so a strobe is never set and cleared in one step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		@(negedge clk_sys_i);
		d = rd_data;
		@(posedge clk_sys_i);
	endtask
	task automatic poll(input logic [7:0] a, input logic [7:0] m, input int lim);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < lim && (d & m) == 8'h00; i++) rd_reg(a, d);
		if ((d & m) == 8'h00) begin
			err_total++;
			$display("[ERR] wait on register %h timed out", a);
			final_report();
		end
	endtask
	// compare value placed a little ahead of the running counter
	task automatic set_cmp(input logic [7:0] a, input logic [15:0] off);
		logic [15:0] t;
		rd_reg(8'h05, lo);
		rd_reg(8'h04, hi);
		t = {hi, lo} + off;
		wr_reg(a, t[15:8]);
		wr_reg(a + 8'h01, t[7:0]);
	endtask
	// =====================================================
	// main sequence
	initial begin
		{rst_i, addr, wdata, wr, rd, ext, cmp_count, err_total} = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		// reset values, unmapped address included
		foreach (RST_ADDR[i]) begin
			rd_reg(RST_ADDR[i], lo);
			check("reset reg", lo, 16'h0000);
		end
		check("reset pins", {ioc_oe, ioc_out}, 16'h0000);
		wr_reg(8'h0C, 8'hA5);
		rd_reg(8'h0C, lo);
		check("irq enable rw", lo, 16'h00A5);
		wr_reg(8'h0D, 8'h78);
		rd_reg(8'h0D, lo);
		check("sys two rw", lo, 16'h0008);
		wr_reg(8'h0C, 8'h00);
		// overflow: free wrap at divide by one, then fast clear by a counter read
		wr_reg(8'h0D, 8'h80);
		poll(8'h0F, 8'h80, 40000);
		repeat (2) @(posedge clk_sys_i);
		check("ovf irq", irq, 16'h0001);
		wr_reg(8'h0F, 8'h00);
		rd_reg(8'h0F, lo);
		check("ovf zero write", lo, 16'h0080);
		wr_reg(8'h06, 8'h10);
		rd_reg(8'h05, lo);
		rd_reg(8'h0F, lo);
		check("ovf fast clear", {irq, lo}, 16'h0000);
		wr_reg(8'h06, 8'h00);
		wr_reg(8'h0D, 8'h00);
		// every compare action code on channel 0
		wr_reg(8'h02, 8'h00);
		wr_reg(8'h00, 8'h01);
		foreach (ACTS[i]) begin
			wr_reg(8'h09, {6'h00, ACTS[i]});
			wr_reg(8'h0E, 8'h01);
			set_cmp(8'h10, 16'h0020);
			poll(8'h0E, 8'h01, 300);
			@(negedge clk_sys_i);
			check("cmp pin", {ioc_oe[0], ioc_out[0]}, {EXP_OE[i], EXP_OUT[i]});
		end
		// interrupt masking and write-one-to-clear
		@(posedge clk_sys_i);
		repeat (2) @(posedge clk_sys_i);
		check("irq masked", irq, 16'h0000);
		wr_reg(8'h0C, 8'h01);
		wr_reg(8'h0E, 8'hFE);
		check("irq enabled", irq, 16'h0001);
		wr_reg(8'h0E, 8'h01);
		@(posedge clk_sys_i);
		rd_reg(8'h0E, lo);
		check("flag cleared", {irq, lo}, 16'h0000);
		// capture edge codes on channel 1, driven from outside
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'h0B, {4'h0, c[1:0], 2'h0});
			wr_reg(8'h0E, 8'h02);
			ext[1] <= 1'b1;
			repeat (8) @(posedge clk_sys_i);
			rd_reg(8'h0E, lo);
			check("rise capture", lo[1], c[0]);
			wr_reg(8'h0E, 8'h02);
			ext[1] <= 1'b0;
			repeat (8) @(posedge clk_sys_i);
			rd_reg(8'h0E, lo);
			check("fall capture", lo[1], c[1]);
		end
		// fast clear by capture read and compare write
		wr_reg(8'h06, 8'h10);
		rd_reg(8'h12, lo);
		set_cmp(8'h10, 16'h0020);
		poll(8'h0E, 8'h01, 300);
		wr_reg(8'h11, 8'h00);
		rd_reg(8'h0E, lo);
		check("fast clear", lo, 16'h0000);
		wr_reg(8'h06, 8'h00);
		// prescale divide by eight: reads seventy-nine cycles apart see ten counts
		wr_reg(8'h0D, 8'h03);
		repeat (300) @(posedge clk_sys_i);
		rd_reg(8'h05, hi);
		repeat (77) @(posedge clk_sys_i);
		rd_reg(8'h05, lo);
		check("prescale", 8'(lo - hi), 16'h000A);
		wr_reg(8'h0D, 8'h00);
		// modulus counting on channel 7 with override of pin 0
		wr_reg(8'h00, 8'h81);
		wr_reg(8'h02, 8'h01);
		wr_reg(8'h03, 8'h01);
		// divide by 128 so the counter sits at zero long enough to retune channel 7
		wr_reg(8'h0D, 8'h0F);
		repeat (130) @(posedge clk_sys_i);
		wr_reg(8'h0E, 8'h80);
		set_cmp(8'h1E, 16'h0004);
		poll(8'h0E, 8'h80, 400);
		// low byte first so the half-written value never lies below the counter
		wr_reg(8'h1F, 8'h10);
		wr_reg(8'h1E, 8'h00);
		for (int i = 0; i < 12; i++) begin
			rd_reg(8'h04, hi);
			rd_reg(8'h05, lo);
			check("modulus", {hi, lo} <= 16'h0010, 16'h0001);
			repeat (200) @(posedge clk_sys_i);
		end
		check("override pin", {ioc_oe[0], ioc_out[0]}, 16'h0003);
		wr_reg(8'h0E, 8'h80);
		poll(8'h0E, 8'h80, 1500);
		wr_reg(8'h1F, 8'h00);
		repeat (300) @(posedge clk_sys_i);
		rd_reg(8'h04, hi);
		rd_reg(8'h05, lo);
		check("held zero", {hi, lo}, 16'h0000);
		final_report();
	end
endmodule
